// [src/cgl_consts.vh]
/*
 Constants for the camera GPIO line control block: register offsets,
 field positions, reset values and timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CGL_CONSTS_VH
`define CGL_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CGL_OFS_INDEX       6'h00
`define CGL_OFS_LINE_CFG    6'h04
`define CGL_OFS_FILT_DG     6'h08
`define CGL_OFS_FILT_DB     6'h0C
`define CGL_OFS_LEVEL_ALL   6'h10
`define CGL_OFS_SOFT_IDX    6'h14
`define CGL_OFS_SOFT_LEVEL  6'h18
`define CGL_OFS_SOFT_WORD   6'h1C

// ----------------------------------------------------------------
// Line configuration fields
// ----------------------------------------------------------------
`define CGL_CFG_DIR_BIT     0
`define CGL_CFG_INV_BIT     1
`define CGL_CFG_DGEN_BIT    2
`define CGL_CFG_DBEN_BIT    3
`define CGL_CFG_SRC_LSB     4
`define CGL_CFG_SRC_MSB     6
`define CGL_CFG_SEL_LSB     8
`define CGL_CFG_SEL_MSB     9
`define CGL_CFG_LEVEL_BIT   16
`define CGL_CFG_FMT_LSB     20
`define CGL_CFG_FMT_MSB     21

// ----------------------------------------------------------------
// Output signal choices and circuit types
// ----------------------------------------------------------------
`define CGL_SRC_LINE        3'h0
`define CGL_SRC_SOFT        3'h1
`define CGL_SRC_COUNTER     3'h2
`define CGL_SRC_LOGIC       3'h3
`define CGL_SRC_EXPOSURE    3'h4
`define CGL_SRC_TRIG_WAIT   3'h5
`define CGL_FMT_TRISTATE    2'h0
`define CGL_FMT_OPTO        2'h1
`define CGL_FMT_OPEN_DRAIN  2'h2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CGL_RST_CFG         8'h00
`define CGL_RST_WIDTH_US    16'h0000
`define CGL_CLK_MHZ         125

`endif

// [src/cgl_sync.v]
/*
 Two flip-flop synchroniser for one asynchronous input bit.
 Assumes clk_i is the block clock and reset is already synchronous-released.
*/
`timescale 1ns/1ps
module cgl_sync (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire d_i,
	output wire q_o
);
	reg meta_r;
	reg sync_r;

	// First stage is read only by the second stage
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // cgl_sync

// [src/cgl_filter.v]
/*
 Input filter for one line: a deglitch stage followed by a debounce stage.
 Assumes a synchronised input and widths in microseconds, stable while used.
*/
`timescale 1ns/1ps
`include "cgl_consts.vh"
module cgl_filter #(
	parameter WIDTH_BITS = 16
) (
	input  wire                  clk_i,
	input  wire                  rst_n_i,
	input  wire                  in_i,
	input  wire                  dg_en_i,
	input  wire                  db_en_i,
	input  wire [WIDTH_BITS-1:0] dg_us_i,
	input  wire [WIDTH_BITS-1:0] db_us_i,
	output wire                  out_o
);
	localparam [6:0] CYC_PER_US = `CGL_CLK_MHZ;

	reg [6:0]            tick_cnt_r;
	reg                  us_tick_r;
	reg                  dg_out_r;
	reg [WIDTH_BITS-1:0] dg_cnt_r;
	reg                  db_out_r;
	reg [WIDTH_BITS-1:0] db_cnt_r;
	wire                 dg_res;

	// ----------------------------------------------------------------
	// Microsecond timebase
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_r <= 7'h00;
			us_tick_r  <= 1'b0;
		end else begin
			us_tick_r  <= (tick_cnt_r == CYC_PER_US - 7'h01);
			tick_cnt_r <= (tick_cnt_r == CYC_PER_US - 7'h01) ? 7'h00 : tick_cnt_r + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Deglitch: new level accepted once it held for the full width
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dg_out_r <= 1'b0;
			dg_cnt_r <= {WIDTH_BITS{1'b0}};
		end else if (in_i == dg_out_r) begin
			dg_cnt_r <= {WIDTH_BITS{1'b0}};
		end else if (dg_cnt_r >= dg_us_i) begin
			dg_out_r <= in_i; // [R07]
			dg_cnt_r <= {WIDTH_BITS{1'b0}};
		end else if (us_tick_r) begin
			dg_cnt_r <= dg_cnt_r + {{(WIDTH_BITS-1){1'b0}}, 1'b1};
		end
	end

	// Deglitch result feeds debounce when both are on
	assign dg_res = dg_en_i ? dg_out_r : in_i; // [R09]

	// ----------------------------------------------------------------
	// Debounce: first edge passes, then state is locked for the width
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			db_out_r <= 1'b0;
			db_cnt_r <= {WIDTH_BITS{1'b0}};
		end else if (db_cnt_r != {WIDTH_BITS{1'b0}}) begin
			if (us_tick_r)
				db_cnt_r <= db_cnt_r - {{(WIDTH_BITS-1){1'b0}}, 1'b1}; // [R08]
		end else if (dg_res != db_out_r) begin
			db_out_r <= dg_res; // [R08]
			db_cnt_r <= db_us_i;
		end
	end

	assign out_o = db_en_i ? db_out_r : dg_res;
endmodule // cgl_filter

// [src/cgl_line_ctrl.v]
/*
 Camera GPIO line control: four lines with direction, polarity, input
 filters, output source selection and software output bits, behind a
 classic Wishbone slave.
 Assumes pins arrive asynchronously and internal sources are on clk_i.
*/
// Functional notes
// [R01] Four lines, index selects per-line settings
// [R02] Per-line direction: input or output
// [R03] Per-line polarity inversion of in/out
// [R04] Per-line level readback, sampled on read
// [R05] All-line level word, bit n line n
// [R06] Per-line deglitch/debounce, own microsecond widths
// [R07] Deglitch accepts level after width persists
// [R08] Debounce passes first edge, then locks
// [R09] Deglitch feeds debounce when both active
// [R10] Output source applies only when output
// [R11] Sources: line, soft, counter, logic, exposure, trigwait
// [R12] Soft index selects bit, level sets it
// [R13] Soft word writes/reads all bits together
// [R14] Read-only circuit type per line
// [R15] Input line leaves driver inactive
`timescale 1ns/1ps
`include "cgl_consts.vh"
module cgl_line_ctrl #(
	parameter NUM_LINES  = 4,
	parameter WIDTH_BITS = 16,
	parameter [2*NUM_LINES-1:0] LINE_FORMATS = {NUM_LINES{`CGL_FMT_OPEN_DRAIN}}
) (
	input  wire                 clk_i,
	input  wire                 reset_n_i,
	input  wire                 wb_cyc_i,
	input  wire                 wb_stb_i,
	input  wire                 wb_we_i,
	input  wire [5:0]           wb_adr_i,
	input  wire [3:0]           wb_sel_i,
	input  wire [31:0]          wb_dat_i,
	output reg  [31:0]          wb_dat_o,
	output wire                 wb_ack_o,
	input  wire [NUM_LINES-1:0] pin_i,
	output reg  [NUM_LINES-1:0] pin_o,
	output reg  [NUM_LINES-1:0] pin_oe_o,
	input  wire [NUM_LINES-1:0] counter_active_i,
	input  wire [NUM_LINES-1:0] logic_block_i,
	input  wire                 exposure_active_i,
	input  wire                 frame_trigger_wait_i,
	output wire [NUM_LINES-1:0] soft_output_word_o
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	// Internal reset leaves two edges after the pin so no flop sees a runt release
	reg rst_meta_r;
	reg rst_n_r;

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	reg [1:0]            pin_index_select_r;
	reg [1:0]            soft_output_index_r;
	reg [NUM_LINES-1:0]  soft_output_word_r;
	reg [NUM_LINES-1:0]  dir_out_r;
	reg [NUM_LINES-1:0]  pin_polarity_invert_r;
	reg [NUM_LINES-1:0]  dg_en_r;
	reg [NUM_LINES-1:0]  db_en_r;
	reg [3*NUM_LINES-1:0] output_signal_choice_r;
	reg [2*NUM_LINES-1:0] loop_sel_r;
	reg [WIDTH_BITS*NUM_LINES-1:0] dg_us_r;
	reg [WIDTH_BITS*NUM_LINES-1:0] db_us_r;
	reg                  ack_r;

	wire [NUM_LINES-1:0] pin_sync;
	wire [NUM_LINES-1:0] pin_filt;
	// Level word is combinational; only a read freezes it
	reg  [NUM_LINES-1:0] all_pins_level_word;
	reg  [NUM_LINES-1:0] drive_level;

	// ----------------------------------------------------------------
	// Bus request decode
	// ----------------------------------------------------------------
	// A request is taken once; the ack cycle itself is never a new request
	wire req   = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr    = req & wb_we_i;
	wire [1:0] idx = pin_index_select_r;

	// ----------------------------------------------------------------
	// Per-line input path and output mux
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_LINES; g = g + 1) begin : g_line
			cgl_sync u_sync (
				.clk_i   (clk_i),
				.rst_n_i (rst_n_r),
				.d_i     (pin_i[g]),
				.q_o     (pin_sync[g])
			);
			// Each line owns its filter counters so widths never alias
			cgl_filter #(.WIDTH_BITS(WIDTH_BITS)) u_filter (
				.clk_i   (clk_i),
				.rst_n_i (rst_n_r),
				.in_i    (pin_sync[g]),
				.dg_en_i (dg_en_r[g]),
				.db_en_i (db_en_r[g]),
				.dg_us_i (dg_us_r[g*WIDTH_BITS +: WIDTH_BITS]),
				.db_us_i (db_us_r[g*WIDTH_BITS +: WIDTH_BITS]),
				.out_o   (pin_filt[g])
			);

			// Source choice matters only while the line drives; oe gates it
			always @* begin
				case (output_signal_choice_r[3*g +: 3]) // [R11]
				`CGL_SRC_LINE: begin
					drive_level[g] = pin_filt[loop_sel_r[2*g +: 2]];
				end
				`CGL_SRC_SOFT: begin
					drive_level[g] = soft_output_word_r[loop_sel_r[2*g +: 2]];
				end
				`CGL_SRC_COUNTER: begin
					drive_level[g] = counter_active_i[loop_sel_r[2*g +: 2]];
				end
				`CGL_SRC_LOGIC: begin
					drive_level[g] = logic_block_i[loop_sel_r[2*g +: 2]];
				end
				`CGL_SRC_EXPOSURE: begin
					drive_level[g] = exposure_active_i;
				end
				`CGL_SRC_TRIG_WAIT: begin
					drive_level[g] = frame_trigger_wait_i;
				end
				default: begin
					drive_level[g] = 1'b0;
				end
				endcase
			end

			// Level shown to software is the line's logical state after inversion
			always @* begin
				if (dir_out_r[g]) begin
					all_pins_level_word[g] = drive_level[g] ^ pin_polarity_invert_r[g]; // [R03]
				end else begin
					all_pins_level_word[g] = pin_filt[g] ^ pin_polarity_invert_r[g]; // [R03]
				end
			end

			// Registered so the pin never shows mux glitches
			always @(posedge clk_i or negedge rst_n_r) begin
				if (!rst_n_r) begin
					pin_o[g]    <= 1'b0;
					pin_oe_o[g] <= 1'b0;
				end else begin
					pin_o[g]    <= drive_level[g] ^ pin_polarity_invert_r[g]; // [R03]
					pin_oe_o[g] <= dir_out_r[g]; // [R02] [R10] [R15]
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_index_select_r     <= 2'h0;
			soft_output_index_r    <= 2'h0;
			soft_output_word_r     <= {NUM_LINES{1'b0}};
			dir_out_r              <= {NUM_LINES{1'b0}};
			pin_polarity_invert_r  <= {NUM_LINES{1'b0}};
			dg_en_r                <= {NUM_LINES{1'b0}};
			db_en_r                <= {NUM_LINES{1'b0}};
			output_signal_choice_r <= {3*NUM_LINES{1'b0}};
			loop_sel_r             <= {2*NUM_LINES{1'b0}};
			dg_us_r                <= {WIDTH_BITS*NUM_LINES{1'b0}};
			db_us_r                <= {WIDTH_BITS*NUM_LINES{1'b0}};
		end else if (wr) begin
			// Writes land at the taking edge, the same edge that raises ack
			case (wb_adr_i)
			`CGL_OFS_INDEX: begin
				if (wb_sel_i[0])
					pin_index_select_r <= wb_dat_i[1:0]; // [R01]
			end
			`CGL_OFS_LINE_CFG: begin
				if (wb_sel_i[0]) begin
					dir_out_r[idx]                  <= wb_dat_i[`CGL_CFG_DIR_BIT]; // [R02]
					pin_polarity_invert_r[idx]      <= wb_dat_i[`CGL_CFG_INV_BIT]; // [R03]
					dg_en_r[idx]                    <= wb_dat_i[`CGL_CFG_DGEN_BIT]; // [R06]
					db_en_r[idx]                    <= wb_dat_i[`CGL_CFG_DBEN_BIT]; // [R06]
					output_signal_choice_r[3*idx +: 3] <= wb_dat_i[`CGL_CFG_SRC_MSB:`CGL_CFG_SRC_LSB]; // [R10]
				end
				if (wb_sel_i[1])
					loop_sel_r[2*idx +: 2] <= wb_dat_i[`CGL_CFG_SEL_MSB:`CGL_CFG_SEL_LSB];
			end
			`CGL_OFS_FILT_DG: begin
				if (wb_sel_i[0])
					dg_us_r[idx*WIDTH_BITS +: 8] <= wb_dat_i[7:0]; // [R06]
				if (wb_sel_i[1])
					dg_us_r[idx*WIDTH_BITS+8 +: 8] <= wb_dat_i[15:8];
			end
			`CGL_OFS_FILT_DB: begin
				if (wb_sel_i[0])
					db_us_r[idx*WIDTH_BITS +: 8] <= wb_dat_i[7:0]; // [R06]
				if (wb_sel_i[1])
					db_us_r[idx*WIDTH_BITS+8 +: 8] <= wb_dat_i[15:8];
			end
			`CGL_OFS_SOFT_IDX: begin
				if (wb_sel_i[0])
					soft_output_index_r <= wb_dat_i[1:0]; // [R12]
			end
			`CGL_OFS_SOFT_LEVEL: begin
				if (wb_sel_i[0])
					soft_output_word_r[soft_output_index_r] <= wb_dat_i[0]; // [R12]
			end
			`CGL_OFS_SOFT_WORD: begin
				if (wb_sel_i[0])
					soft_output_word_r <= wb_dat_i[NUM_LINES-1:0]; // [R13]
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------
	// Unused bits read as zero so software can mask fields freely
	reg [31:0] rd_data_nxt;

	always @* begin
		rd_data_nxt = 32'h00000000;
		case (wb_adr_i)
		`CGL_OFS_INDEX: begin
			rd_data_nxt[1:0] = pin_index_select_r;
		end
		`CGL_OFS_LINE_CFG: begin
			rd_data_nxt[`CGL_CFG_DIR_BIT]  = dir_out_r[idx];
			rd_data_nxt[`CGL_CFG_INV_BIT]  = pin_polarity_invert_r[idx];
			rd_data_nxt[`CGL_CFG_DGEN_BIT] = dg_en_r[idx];
			rd_data_nxt[`CGL_CFG_DBEN_BIT] = db_en_r[idx];
			rd_data_nxt[`CGL_CFG_SRC_MSB:`CGL_CFG_SRC_LSB] = output_signal_choice_r[3*idx +: 3];
			rd_data_nxt[`CGL_CFG_SEL_MSB:`CGL_CFG_SEL_LSB] = loop_sel_r[2*idx +: 2];
			rd_data_nxt[`CGL_CFG_LEVEL_BIT] = all_pins_level_word[idx]; // [R04]
			rd_data_nxt[`CGL_CFG_FMT_MSB:`CGL_CFG_FMT_LSB] = LINE_FORMATS[2*idx +: 2]; // [R14]
		end
		`CGL_OFS_FILT_DG: begin
			rd_data_nxt[WIDTH_BITS-1:0] = dg_us_r[idx*WIDTH_BITS +: WIDTH_BITS];
		end
		`CGL_OFS_FILT_DB: begin
			rd_data_nxt[WIDTH_BITS-1:0] = db_us_r[idx*WIDTH_BITS +: WIDTH_BITS];
		end
		`CGL_OFS_LEVEL_ALL: begin
			rd_data_nxt[NUM_LINES-1:0] = all_pins_level_word; // [R05]
		end
		`CGL_OFS_SOFT_IDX: begin
			rd_data_nxt[1:0] = soft_output_index_r;
		end
		`CGL_OFS_SOFT_LEVEL: begin
			rd_data_nxt[0] = soft_output_word_r[soft_output_index_r];
		end
		`CGL_OFS_SOFT_WORD: begin
			rd_data_nxt[NUM_LINES-1:0] = soft_output_word_r; // [R13]
		end
		default: begin
			rd_data_nxt = 32'h00000000;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// Read path and acknowledge
	// ----------------------------------------------------------------
	// Read data is captured at the request so level is a poll-time snapshot
	// Data stays put between reads, so a poll sees one instant
	always @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wb_dat_o <= 32'h00000000;
			ack_r    <= 1'b0;
		end else begin
			ack_r <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= rd_data_nxt;
			end
		end
	end

	assign wb_ack_o           = ack_r;
	assign soft_output_word_o = soft_output_word_r;
endmodule // cgl_line_ctrl

// [tb/cgl_line_properties.sv]
/*
 Checker for the camera GPIO line control block: bus handshake and
 register-driven outputs. Assumes it is bound to cgl_line_ctrl.
*/
`timescale 1ns/1ps
module cgl_line_props #(
	parameter NUM_LINES = 4
) (
	input  wire                 clk_i,
	input  wire                 reset_n_i,
	input  wire                 wb_cyc_i,
	input  wire                 wb_stb_i,
	input  wire                 wb_we_i,
	input  wire [31:0]          wb_dat_o,
	input  wire                 wb_ack_o,
	input  wire [NUM_LINES-1:0] pin_oe_o,
	input  wire [NUM_LINES-1:0] soft_output_word_o
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_ack_one_late: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_ack_bound: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##1 wb_ack_o ##1 !wb_ack_o)
		else $error("ack pulse shape wrong");
	a_idle_no_ack: assert property ((!wb_cyc_i ##1 !wb_cyc_i) |-> !wb_ack_o)
		else $error("ack while bus idle");
	// Readback is sampled only when software polls, so data moves only on a read
	a_rd_data_held: assert property ($changed(wb_dat_o) |->
		(wb_ack_o || $past(wb_ack_o)) && !$past(wb_we_i))
		else $error("read data changed without read");
	a_soft_word_write: assert property ($changed(soft_output_word_o) |->
		(wb_ack_o || $past(wb_ack_o)) && $past(wb_we_i))
		else $error("soft word changed without write");
	a_oe_after_cfg: assert property ($changed(pin_oe_o) |->
		(wb_ack_o || $past(wb_ack_o)) && $past(wb_we_i))
		else $error("output enable changed without write");
endmodule // cgl_line_props

bind cgl_line_ctrl cgl_line_props #(.NUM_LINES(NUM_LINES)) u_props (
	.clk_i              (clk_i),
	.reset_n_i          (reset_n_i),
	.wb_cyc_i           (wb_cyc_i),
	.wb_stb_i           (wb_stb_i),
	.wb_we_i            (wb_we_i),
	.wb_dat_o           (wb_dat_o),
	.wb_ack_o           (wb_ack_o),
	.pin_oe_o           (pin_oe_o),
	.soft_output_word_o (soft_output_word_o)
);

// [tb/cgl_ext_circuit.sv]
/*
 External circuit at the four open-drain lines: pull-up plus an
 optional driver per line. Assumes the bench never drives a line high
 while the device pulls it low.
*/
`timescale 1ns/1ps
module cgl_ext_circuit (
	input  wire [3:0] pin_o,
	input  wire [3:0] pin_oe_o,
	input  wire [3:0] ext_en_i,
	input  wire [3:0] ext_val_i,
	output wire [3:0] pin_i
);
	// Released line floats to the pull-up, not to the last driven value
	assign pin_i = ~(pin_oe_o & ~pin_o) & (ext_val_i | ~ext_en_i);
endmodule // cgl_ext_circuit

// [tb/testbench.sv]
/*
 Self-checking bench for cgl_line_ctrl over classic Wishbone.
 Assumes cgl_ext_circuit models the pins and default parameters.
*/
`timescale 1ns/1ps
`include "cgl_consts.vh"
module testbench;
	reg         clk_i, reset_n_i, cyc, stb, we;
	reg  [5:0]  adr;
	reg  [31:0] dat, rdat, sw;
	reg  [3:0]  cnt_act, lgc_blk, ext_en, ext_val, v;
	reg         expo, trig, inv;
	reg  [1:0]  k;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o;
	wire [3:0]  pin_i, pin_o, pin_oe_o, soft_o;
	integer     num_errors, n_tests, tmo, i, s;

	cgl_line_ctrl u_cgl_line_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.counter_active_i(cnt_act), .logic_block_i(lgc_blk), .exposure_active_i(expo),
		.frame_trigger_wait_i(trig), .soft_output_word_o(soft_o));
	cgl_ext_circuit u_cgl_ext_circuit (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pin_i(pin_i));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task end_sim;
		begin
			$display("tests %0d errors %0d", n_tests, num_errors);
			if (num_errors == 0 && n_tests > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("[ERR] %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// Request held until ack is seen high at an edge, released at that edge
	task bus(input [5:0] a, input w, input [31:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we  <= w;
			adr <= a;
			dat <= d;
			do @(posedge clk_i); while (wb_ack_o !== 1'b1);
			rdat = wb_dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask
	task cfg(input [1:0] l, input [31:0] d);
		begin
			bus(`CGL_OFS_INDEX, 1'b1, {30'h0, l});
			bus(`CGL_OFS_LINE_CFG, 1'b1, d);
		end
	endtask
	task lv(input [1:0] l, input e, input string nm);
		begin
			bus(`CGL_OFS_LEVEL_ALL, 1'b0, 32'h0);
			chk(nm, {31'h0, e}, {31'h0, rdat[l]});
		end
	endtask
	function exp_src(input [2:0] sc, input [1:0] kk);
		case (sc)
			`CGL_SRC_LINE:     exp_src = ext_val[kk];
			`CGL_SRC_SOFT:     exp_src = sw[kk];
			`CGL_SRC_COUNTER:  exp_src = cnt_act[kk];
			`CGL_SRC_LOGIC:    exp_src = lgc_blk[kk];
			`CGL_SRC_EXPOSURE: exp_src = expo;
			default:           exp_src = trig;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			num_errors = num_errors + 1;
			end_sim;
		end
	end
	initial begin
		{cyc, stb, we, adr, dat, expo, trig} = 0;
		{cnt_act, lgc_blk, ext_en, ext_val} = 0;
		num_errors = 0;
		n_tests = 0;
		tmo = 0;
		reset_n_i = 1'b0;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sw = $urandom(15);
		for (i = 0; i < 4; i = i + 1) begin
			bus(`CGL_OFS_INDEX, 1'b1, i);
			bus(`CGL_OFS_LINE_CFG, 1'b0, 32'h0);
			chk("cfg_reset", 32'h0021_0000, rdat);
		end
		bus(6'h20, 1'b1, 32'hFFFF_FFFF);
		bus(6'h20, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rdat);
		sw = $urandom & 32'hF;
		bus(`CGL_OFS_SOFT_WORD, 1'b1, sw);
		bus(`CGL_OFS_SOFT_WORD, 1'b0, 32'h0);
		chk("soft_word", sw, rdat);
		chk("soft_port", sw, {28'h0, soft_o});
		for (i = 0; i < 4; i = i + 1) begin
			sw[i] = $urandom;
			bus(`CGL_OFS_SOFT_IDX, 1'b1, i);
			bus(`CGL_OFS_SOFT_LEVEL, 1'b1, {31'h0, sw[i]});
		end
		chk("soft_level", sw, {28'h0, soft_o});
		ext_en <= 4'h1;
		ext_val <= $urandom;
		for (s = 0; s < 6; s = s + 1) begin
			cnt_act <= $urandom;
			lgc_blk <= $urandom;
			expo <= $urandom;
			trig <= $urandom;
			k = (s == 0) ? 2'h0 : $urandom;
			inv = $urandom;
			cfg(2'h1, {22'h0, k, 1'b0, s[2:0], 2'b00, inv, 1'b1});
			repeat (12) @(posedge clk_i);
			chk("src_pin", {31'h0, inv ^ exp_src(s, k)}, {31'h0, pin_o[1]});
			chk("src_oe", 32'h1, {31'h0, pin_oe_o[1]});
		end
		cfg(2'h1, 32'h10);
		repeat (4) @(posedge clk_i);
		chk("input_oe", 32'h0, {28'h0, pin_oe_o});
		ext_en <= 4'hF;
		v = $urandom;
		ext_val <= v;
		cfg(2'h2, 32'h2);
		repeat (10) @(posedge clk_i);
		bus(`CGL_OFS_LEVEL_ALL, 1'b0, 32'h0);
		chk("level_all", {28'h0, v ^ 4'h4}, rdat);
		bus(`CGL_OFS_INDEX, 1'b1, 32'h3);
		bus(`CGL_OFS_LINE_CFG, 1'b0, 32'h0);
		chk("level_sel", {31'h0, v[3]}, {31'h0, rdat[16]});
		// Deglitch 4 us on line 3: a 1 us pulse must vanish
		cfg(2'h3, 32'h4);
		bus(`CGL_OFS_FILT_DG, 1'b1, 32'h4);
		ext_val[3] <= 1'b0;
		repeat (700) @(posedge clk_i);
		ext_val[3] <= 1'b1;
		repeat (125) @(posedge clk_i);
		ext_val[3] <= 1'b0;
		repeat (700) @(posedge clk_i);
		lv(2'h3, 1'b0, "dg_pulse");
		ext_val[3] <= 1'b1;
		repeat (250) @(posedge clk_i);
		lv(2'h3, 1'b0, "dg_delay");
		repeat (500) @(posedge clk_i);
		lv(2'h3, 1'b1, "dg_accept");
		// Debounce 4 us on line 2: first edge passes, then locks
		cfg(2'h2, 32'h8);
		bus(`CGL_OFS_FILT_DB, 1'b1, 32'h4);
		ext_val[2] <= 1'b0;
		repeat (700) @(posedge clk_i);
		ext_val[2] <= 1'b1;
		repeat (20) @(posedge clk_i);
		lv(2'h2, 1'b1, "db_first");
		ext_val[2] <= 1'b0;
		repeat (125) @(posedge clk_i);
		lv(2'h2, 1'b1, "db_lock");
		repeat (750) @(posedge clk_i);
		lv(2'h2, 1'b0, "db_release");
		end_sim;
	end
endmodule // testbench
